//--- rtl/ds3_flexible_bandwidth_port.sv
`timescale 1ns/100ps
module ds3_flexible_bandwidth_port
  import flex_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode
  input wire logic access_ungapped,
  // Ingress line side
  input wire logic ingress_line_clk,
  input wire logic ingress_line_data,
  // Ingress partner side
  output logic ingress_frame_data,
  output logic ingress_frame_overhead,
  output logic ingress_payload_clk,
  input wire logic ingress_bit_enable,
  // Drop bus
  output logic [7:0] drop_data,
  output logic drop_valid,
  input wire logic drop_ready,
  // Egress partner side
  input wire logic egress_bit_request,
  output logic egress_bit_enable,
  output logic egress_bit_data,
  output logic transmit_multiframe_pulse_out,
  // Egress line side
  input wire logic egress_line_clk,
  output logic egress_line_data,
  // Add bus
  input wire logic [7:0] add_data,
  input wire logic add_valid,
  output logic add_ready,
  output logic add_bus_justification_request
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] ilc_sync_reg, ild_sync_reg, ien_sync_reg, elc_sync_reg, erq_sync_reg;
  logic ilc_prev_reg, elc_prev_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ilc_sync_reg <= '0;
      ild_sync_reg <= '0;
      ien_sync_reg <= '0;
      elc_sync_reg <= '0;
      erq_sync_reg <= '0;
      ilc_prev_reg <= 1'b0;
      elc_prev_reg <= 1'b0;
    end else begin
      ilc_sync_reg <= {ilc_sync_reg[0], ingress_line_clk};
      ild_sync_reg <= {ild_sync_reg[0], ingress_line_data};
      ien_sync_reg <= {ien_sync_reg[0], ingress_bit_enable};
      elc_sync_reg <= {elc_sync_reg[0], egress_line_clk};
      erq_sync_reg <= {erq_sync_reg[0], egress_bit_request};
      ilc_prev_reg <= ilc_sync_reg[1];
      elc_prev_reg <= elc_sync_reg[1];
    end
  end
  logic ing_edge, eg_edge;
  assign ing_edge = ilc_sync_reg[1] && !ilc_prev_reg;
  assign eg_edge = elc_sync_reg[1] && !elc_prev_reg;
  // ---------------------------------------------------------------------------
  // Ingress framing position and partner presentation
  // ---------------------------------------------------------------------------
  // The ingress counter free-runs from reset; alignment search is out of scope.
  logic [6:0] ipos_reg, ipos_next;
  line_bit_t ipres_reg, ipres_next;
  logic pclk_reg, pclk_next;
  always_comb begin
    ipos_next = ipos_reg;
    ipres_next = ipres_reg;
    pclk_next = 1'b0;
    if (ing_edge) begin
      ipres_next.data = ild_sync_reg[1];
      ipres_next.overhead = (ipos_reg == OVH_POS);
      ipres_next.clk_edge = 1'b1;
      // Gapped mode suppresses the payload clock pulse over overhead.
      pclk_next = access_ungapped || (ipos_reg != OVH_POS);
      ipos_next = (ipos_reg == BLOCK_LAST) ? '0 : 7'(ipos_reg + 1'b1);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ipos_reg <= '0;
      ipres_reg <= '0;
      pclk_reg <= 1'b0;
    end else begin
      ipos_reg <= ipos_next;
      ipres_reg <= ipres_next;
      pclk_reg <= pclk_next;
    end
  end
  assign ingress_frame_data = ipres_reg.data;
  assign ingress_frame_overhead = ipres_reg.overhead;
  assign ingress_payload_clk = pclk_reg;
  // ---------------------------------------------------------------------------
  // Ingress byte packing into the drop FIFO
  // ---------------------------------------------------------------------------
  // The enable is judged on the bit presented one slot earlier, so the partner
  // has a whole line bit period to decide.
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bcnt_reg, bcnt_next;
  logic push_reg, push_next;
  sys_byte_t pbyte_reg, pbyte_next;
  logic drop_in_ready;
  always_comb begin
    shift_next = shift_reg;
    bcnt_next = bcnt_reg;
    push_next = push_reg && !drop_in_ready;
    pbyte_next = pbyte_reg;
    if (ing_edge && ien_sync_reg[1] && !ipres_reg.overhead) begin
      shift_next = {shift_reg[6:0], ipres_reg.data};
      bcnt_next = 3'(bcnt_reg + 1'b1);
      if (bcnt_reg == BIT_LAST) begin
        pbyte_next.data = {shift_reg[6:0], ipres_reg.data};
        push_next = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
      bcnt_reg <= '0;
      push_reg <= 1'b0;
      pbyte_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      bcnt_reg <= bcnt_next;
      push_reg <= push_next;
      pbyte_reg <= pbyte_next;
    end
  end
  flex_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) drop_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_reg),
    .in_ready(drop_in_ready),
    .in_data(pbyte_reg.data),
    .out_valid(drop_valid),
    .out_ready(drop_ready && drop_valid),
    .out_data(drop_data),
    .fill()
  );
  // ---------------------------------------------------------------------------
  // Egress add FIFO, justification and bit handshake
  // ---------------------------------------------------------------------------
  logic add_fvalid, bit_take;
  logic [7:0] add_fdata;
  logic [2:0] add_fill;
  flex_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) add_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(add_valid),
    .in_ready(add_ready),
    .in_data(add_data),
    .out_valid(add_fvalid),
    .out_ready(bit_take),
    .out_data(add_fdata),
    .fill(add_fill)
  );
  egress_state_t est_reg, est_next;
  logic [2:0] ebit_reg, ebit_next;
  logic een_reg, een_next, edat_reg, edat_next, just_reg, just_next;
  always_comb begin
    est_next = est_reg;
    ebit_next = ebit_reg;
    een_next = 1'b0;
    edat_next = edat_reg;
    bit_take = 1'b0;
    // Request more bytes while the fill sits below centre, stop above it.
    just_next = (add_fill <= FILL_LOW) ? 1'b1 : (add_fill >= FILL_HIGH) ? 1'b0 : just_reg;
    unique case (est_reg)
      EG_IDLE: begin
        if (erq_sync_reg[1] && add_fvalid) begin
          est_next = EG_GRANT;
        end
      end
      EG_GRANT: begin
        een_next = 1'b1;
        edat_next = add_fdata[3'(BIT_LAST - ebit_reg)];
        ebit_next = 3'(ebit_reg + 1'b1);
        bit_take = (ebit_reg == BIT_LAST);
        est_next = EG_WAIT_DROP;
      end
      EG_WAIT_DROP: begin
        // One bit per request: the request must fall before another grant.
        if (!erq_sync_reg[1]) begin
          est_next = EG_IDLE;
        end
      end
      default: est_next = EG_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      est_reg <= EG_IDLE;
      ebit_reg <= '0;
      een_reg <= 1'b0;
      edat_reg <= 1'b0;
      just_reg <= 1'b0;
    end else begin
      est_reg <= est_next;
      ebit_reg <= ebit_next;
      een_reg <= een_next;
      edat_reg <= edat_next;
      just_reg <= just_next;
    end
  end
  assign egress_bit_enable = een_reg;
  assign egress_bit_data = edat_reg;
  assign add_bus_justification_request = just_reg;
  // ---------------------------------------------------------------------------
  // Egress framing: overhead insertion and multiframe pulse
  // ---------------------------------------------------------------------------
  // Payload bits not filled by the partner are sent as the last granted bit;
  // the partner paces its buffer from the multiframe pulse.
  logic [6:0] epos_reg, epos_next;
  logic [2:0] eblk_reg, eblk_next, esub_reg, esub_next;
  logic eline_reg, eline_next, mfp_reg, mfp_next;
  always_comb begin
    epos_next = epos_reg;
    eblk_next = eblk_reg;
    esub_next = esub_reg;
    eline_next = eline_reg;
    mfp_next = 1'b0;
    if (eg_edge) begin
      // Overhead bits alternate as a simple framing pattern.
      eline_next = (epos_reg == OVH_POS) ? eblk_reg[0] : edat_reg;
      mfp_next = (epos_reg == OVH_POS) && (eblk_reg == '0) && (esub_reg == '0);
      epos_next = (epos_reg == BLOCK_LAST) ? '0 : 7'(epos_reg + 1'b1);
      if (epos_reg == BLOCK_LAST) begin
        eblk_next = 3'(eblk_reg + 1'b1);
        if (eblk_reg == BLOCK_IDX_LAST) begin
          esub_next = (esub_reg == SUB_LAST) ? 3'h0 : 3'(esub_reg + 1'b1);
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      epos_reg <= '0;
      eblk_reg <= '0;
      esub_reg <= '0;
      eline_reg <= 1'b0;
      mfp_reg <= 1'b0;
    end else begin
      epos_reg <= epos_next;
      eblk_reg <= eblk_next;
      esub_reg <= esub_next;
      eline_reg <= eline_next;
      mfp_reg <= mfp_next;
    end
  end
  assign egress_line_data = eline_reg;
  assign transmit_multiframe_pulse_out = mfp_reg;
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence grant_s;
    est_reg == EG_GRANT;
  endsequence
  sequence enable_s;
    een_reg ##1 !een_reg;
  endsequence
  egress_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
    grant_s |=> enable_s) else $error("egress enable not one pulse after grant");
  egress_request_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(een_reg) |-> $past(erq_sync_reg[1], 2)) else $error("enable without request");
  single_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
    een_reg |=> !een_reg [*2]) else $error("grants too close");
  gap_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!$past(access_ungapped) && ipres_reg.overhead && $changed(ipres_reg.overhead))
    |-> !pclk_reg) else $error("gapped clock pulsed at overhead");
  ungap_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(access_ungapped) && $past(ing_edge)) |-> pclk_reg)
    else $error("ungapped clock missing");
  pack_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (push_next && !push_reg) |-> (bcnt_reg == BIT_LAST)) else $error("byte push off count");
  ingress_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    ing_edge |=> ipres_reg.data == $past(ild_sync_reg[1])) else $error("ingress data lost");
  just_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (add_fill <= FILL_LOW) |=> just_reg) else $error("no justification when low");
  mf_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    mfp_reg |-> (epos_reg == 7'h0001) && eblk_reg == '0 && esub_reg == '0)
    else $error("multiframe pulse misplaced");
endmodule

//--- rtl/flex_fifo.sv
`timescale 1ns/100ps
module flex_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic [$clog2(DEPTH):0] fill
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign fill = cnt_reg;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

//--- rtl/flex_port_pkg.sv
package flex_port_pkg;
  // ---------------------------------------------------------------------------
  // DS3 frame geometry
  // ---------------------------------------------------------------------------
  // A DS3 M-subframe is 680 bits: one overhead bit then 84 payload bits, eight
  // times. Seven subframes form the multiframe.
  localparam int BLOCK_LEN = 85;
  localparam int BLOCKS_PER_SUB = 8;
  localparam int SUBS_PER_MF = 7;
  localparam logic [6:0] BLOCK_LAST = 7'h0054;
  localparam logic [2:0] BLOCK_IDX_LAST = 3'h7;
  localparam logic [2:0] SUB_LAST = 3'h6;
  localparam logic [6:0] OVH_POS = 7'h0000;
  // ---------------------------------------------------------------------------
  // Link and buffer sizes
  // ---------------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Justification request thresholds around the centred fill level.
  localparam logic [2:0] FILL_LOW = 3'h1;
  localparam logic [2:0] FILL_HIGH = 3'h3;
  // ---------------------------------------------------------------------------
  // Payload access modes
  // ---------------------------------------------------------------------------
  typedef enum logic {
    ACCESS_GAPPED = 1'b0,
    ACCESS_UNGAPPED = 1'b1
  } access_mode_t;
  // Line side serial bit with its clock edge and overhead marking.
  typedef struct packed {
    logic clk_edge;
    logic data;
    logic overhead;
  } line_bit_t;
  // Byte travelling on the system side.
  typedef struct packed {
    logic [7:0] data;
  } sys_byte_t;
  // Egress handshake state.
  typedef enum logic [1:0] {
    EG_IDLE = 2'b00,
    EG_GRANT = 2'b01,
    EG_WAIT_DROP = 2'b10
  } egress_state_t;
endpackage

//--- verification/ds3_flexible_bandwidth_port_tb_top.sv
`timescale 1ns/100ps
module ds3_flexible_bandwidth_port_tb_top;
  import flex_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic access_ungapped = 1'b0;
  logic ingress_line_clk = 1'b0;
  logic ingress_line_data = 1'b0;
  logic egress_line_clk = 1'b0;
  logic drop_ready = 1'b0;
  logic [7:0] add_data = 8'h00;
  logic add_valid = 1'b0;
  logic ingress_frame_data, ingress_frame_overhead, ingress_payload_clk, ingress_bit_enable;
  logic [7:0] drop_data;
  logic drop_valid, egress_bit_request, egress_bit_enable, egress_bit_data;
  logic transmit_multiframe_pulse_out, egress_line_data, add_ready;
  logic add_bus_justification_request;
  int miscompares = 0;
  int checked = 0;
  int line_cnt = 0;
  int eg_bits = 0;
  logic [7:0] drop_q[$];

  ds3_flexible_bandwidth_port uut (.clk, .rst_n, .access_ungapped, .ingress_line_clk,
    .ingress_line_data, .ingress_frame_data, .ingress_frame_overhead, .ingress_payload_clk,
    .ingress_bit_enable, .drop_data, .drop_valid, .drop_ready, .egress_bit_request,
    .egress_bit_enable, .egress_bit_data, .transmit_multiframe_pulse_out, .egress_line_clk,
    .egress_line_data, .add_data, .add_valid, .add_ready, .add_bus_justification_request);

  flex_partner partner (.clk, .rst_n, .access_ungapped, .ingress_frame_data,
    .ingress_frame_overhead, .ingress_payload_clk, .ingress_bit_enable, .egress_bit_request,
    .egress_bit_enable, .egress_bit_data, .transmit_multiframe_pulse_out);

  // ---------------------------------------------------------------
  // Clocks and line stimulus
  // ---------------------------------------------------------------
  initial forever #12.5 clk = ~clk;
  // Line clocks are free running and offset so their edges never meet the system clock.
  initial begin
    #7;
    forever #100 ingress_line_clk = ~ingress_line_clk;
  end
  initial begin
    #61;
    forever #100 egress_line_clk = ~egress_line_clk;
  end
  always @(negedge ingress_line_clk) begin
    line_cnt++;
    ingress_line_data <= line_cnt[0] ^ line_cnt[3];
  end
  // Egress line bits are counted from reset so overhead positions can be predicted.
  always @(posedge egress_line_clk)
    if (rst_n)
      eg_bits++;
  // The drop side stalls every other cycle.
  always @(negedge clk)
    drop_ready <= ~drop_ready;
  always @(posedge clk)
    if (drop_valid === 1'b1 && drop_ready === 1'b1)
      drop_q.push_back(drop_data);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expire(string what);
    check(what, 8'h00, 8'h01);
    conclude();
  endtask

  task automatic push(logic [7:0] b);
    int n;
    n = 0;
    add_valid = 1'b1;
    add_data = b;
    @(posedge clk);
    while (add_ready !== 1'b1) begin
      if (++n > 50)
        expire("add_wait");
      @(posedge clk);
    end
    @(negedge clk);
  endtask

  task automatic wait_eg();
    int n;
    n = 0;
    while (partner.eg_left > 0) begin
      if (++n > 5000)
        expire("egress_wait");
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
  endtask

  task automatic take_eg(logic [7:0] exp);
    logic [7:0] b;
    repeat (8) b = {b[6:0], partner.eg_q.pop_front()};
    check("egress_byte", exp, b);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic egress_path();
    logic [7:0] bytes[4];
    bytes = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
    check("just_empty", 8'h01, {7'h00, add_bus_justification_request});
    partner.eg_left = 1;
    repeat (60) @(negedge clk);
    check("eg_refused", 8'h00, 8'(partner.eg_q.size()));
    push(8'h5A);
    add_valid = 1'b0;
    wait_eg();
    partner.eg_left = 7;
    wait_eg();
    take_eg(8'h5A);
    foreach (bytes[i])
      push(bytes[i]);
    add_data = 8'h77;
    repeat (4) @(negedge clk);
    check("add_full", 8'h00, {7'h00, add_ready});
    check("just_full", 8'h00, {7'h00, add_bus_justification_request});
    add_valid = 1'b0;
    partner.eg_left = 16;
    wait_eg();
    check("just_held", 8'h00, {7'h00, add_bus_justification_request});
    partner.eg_gap = 20;
    partner.eg_left = 8;
    wait_eg();
    check("just_low_fill", 8'h01, {7'h00, add_bus_justification_request});
    partner.eg_left = 8;
    wait_eg();
    foreach (bytes[i])
      take_eg(bytes[i]);
    partner.eg_gap = 2;
  endtask

  // Overhead alternates per block; a multiframe outlasts the run, so one pulse only.
  task automatic egress_frame();
    int k;
    repeat (180) begin
      @(negedge egress_line_clk);
      k = eg_bits - 1;
      if (k % BLOCK_LEN == 0)
        check("overhead_bit", 8'((k / BLOCK_LEN) % 2), {7'h00, egress_line_data});
    end
    @(negedge clk);
    check("mf_pulses", 8'h01, 8'(partner.mf_seen));
  endtask

  task automatic ingress_mode(logic mode, logic [7:0] pulses);
    int n;
    int ovh;
    logic [7:0] b;
    n = 0;
    ovh = 0;
    access_ungapped = mode;
    repeat (100) @(negedge clk);
    // Exactly 170 line bits fall in this window, two of them overhead.
    repeat (1360) begin
      @(posedge clk);
      if (ingress_payload_clk === 1'b1) begin
        n++;
        if (ingress_frame_overhead === 1'b1)
          ovh++;
      end
    end
    @(negedge clk);
    check("payload_clk_count", pulses, n[7:0]);
    check("overhead_count", mode ? 8'h02 : 8'h00, ovh[7:0]);
    drop_q.delete();
    partner.ing_q.delete();
    partner.ing_limit = 24;
    n = 0;
    while (drop_q.size() < 3) begin
      if (++n > 20000)
        expire("drop_wait");
      @(negedge clk);
    end
    repeat (200) @(negedge clk);
    check("drop_count", 8'h03, 8'(drop_q.size()));
    for (int i = 0; i < 3; i++) begin
      repeat (8) b = {b[6:0], partner.ing_q.pop_front()};
      check("drop_byte", b, drop_q[i]);
    end
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    egress_path();
    ingress_mode(1'b0, 8'hA8);
    ingress_mode(1'b1, 8'hAA);
    egress_frame();
    conclude();
  end
endmodule

//--- verification/flex_partner.sv
`timescale 1ns/100ps
module flex_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Ingress side
  input wire logic access_ungapped,
  input wire logic ingress_frame_data,
  input wire logic ingress_frame_overhead,
  input wire logic ingress_payload_clk,
  output logic ingress_bit_enable,
  // Egress side
  output logic egress_bit_request,
  input wire logic egress_bit_enable,
  input wire logic egress_bit_data,
  input wire logic transmit_multiframe_pulse_out
);
  int ing_limit = 0;
  int eg_left = 0;
  int eg_gap = 2;
  int wait_cnt = 0;
  int sel = 0;
  int mf_seen = 0;
  logic ing_q[$];
  logic eg_q[$];

  initial begin
    ingress_bit_enable = 1'b0;
    egress_bit_request = 1'b0;
  end

  always @(posedge clk) begin
    if (transmit_multiframe_pulse_out === 1'b1)
      mf_seen++;
    if (ingress_payload_clk === 1'b1) begin
      sel++;
      // Every third payload bit is left unused, so skipped bits must not reach a byte.
      if (ing_limit > 0 && sel % 3 != 0 && !(access_ungapped && ingress_frame_overhead)) begin
        ing_q.push_back(ingress_frame_data);
        ing_limit--;
        ingress_bit_enable <= 1'b1;
      end else begin
        ingress_bit_enable <= 1'b0;
      end
    end
    // A request is held until its enable is sampled, then dropped before the next one.
    if (egress_bit_request && egress_bit_enable === 1'b1) begin
      eg_q.push_back(egress_bit_data);
      eg_left--;
      egress_bit_request <= 1'b0;
      wait_cnt = 0;
    end else if (!egress_bit_request && eg_left > 0 && rst_n) begin
      if (wait_cnt >= eg_gap)
        egress_bit_request <= 1'b1;
      else
        wait_cnt++;
    end
  end
endmodule
